// ==== hms_pkg.sv ====
// Constants, register map and state type of the haptic mode sequencer.
//------------------------------------------------------------------------
// Notes on behaviour
// - Shutdown powers everything off; the register port answers every access with an error.
// - Supply good and enable low: start bias, then pending standby.
// - Host must read the ready flag, clearing it, before plain standby.
// - Pending standby acts as standby but refuses to start playback.
// - Reading interrupt status clears flags and moves pending to standby.
// - Standby keeps the output off; registers stay fully accessible.
// - A haptic request is play enable set or a queue write in standby.
// - On request enable pumps and analog, then ramp code to minimum.
// - Enter playback only once output ready shows the 10V floor.
// - When done ramp code to zero, disable output, then pumps.
// - Ramp-down done with enable low returns to standby.
// - Ramp-down done with enable high goes to shutdown.
// - Any fault abandons the state, ramps to 10V, disables converter; here only faults from pump-up through output-off act, others are ignored.
// - After a fault wait the settle delay, 2ms default, then pumps off.
// - Delay done, enable low, auto-rearm 0: pending standby.
// - Delay done, enable low, auto-rearm 1: straight to standby.
// - Delay done with enable high goes to shutdown.
// - Enable high in either standby state goes to shutdown.
// - Entering shutdown clears registers, wave memory and queue.
// - After enable falls, pending standby is reached within 1ms.
//------------------------------------------------------------------------
package hms_pkg;

    //--------------------------------------------------------------------
    // Register map.
    //--------------------------------------------------------------------
    localparam int         APB_ADDR_W      = 8;
    localparam logic [7:0] INTR_STAT_ADDR  = 8'h00;
    localparam logic [7:0] CTRL_ADDR       = 8'h04;
    localparam logic [7:0] FDLY_ADDR       = 8'h08;
    localparam logic [7:0] QUEUE_ADDR      = 8'h0c;
    localparam logic [7:0] MODE_ADDR       = 8'h10;

    // Field positions.
    localparam int SPR_FLAG_POS   = 0;
    localparam int FAULT_FLAG_POS = 1;
    localparam int PLAY_EN_POS    = 0;
    localparam int REARM_POS      = 1;

    // Values after reset.
    localparam logic [1:0]  FLAGS_RST       = 2'h0;
    localparam logic [15:0] FDLY_RST_US     = 16'h07d0;
    localparam logic [11:0] DAC_MIN_RST     = 12'h100;

    //--------------------------------------------------------------------
    // Timing.
    //--------------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 50;
    localparam int US_NS            = 1000;
    localparam int US_CYCLES        = (US_NS + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
    localparam int RAMP_STEP_CYCLES = 4;

    // Operating modes.
    typedef enum logic [3:0] {
        ST_SHUTDOWN,
        ST_WAKE,
        ST_STBY_PEND,
        ST_STBY,
        ST_PUMP_UP,
        ST_RAMP_UP,
        ST_PLAY,
        ST_RAMP_DOWN,
        ST_OUT_OFF,
        ST_FAULT_RAMP,
        ST_FAULT_WAIT
    } hms_state_t;

endpackage

// ==== hms_sync.sv ====
// Two-flop level synchroniser for a group of asynchronous inputs.
`timescale 1ns/1ns
`default_nettype none
module hms_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk_i,
    input  wire logic         resetn_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] stage1;

    //--------------------------------------------------------------------
    // Only the second flop reads the first, to contain metastability.
    //--------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stage1 <= '0;
            sync_o <= '0;
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end

endmodule // hms_sync
`default_nettype wire

// ==== hms_haptic_mode_sequencer.sv ====
// Operating-mode sequencer of a piezo haptic driver with an APB slave.
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module hms_haptic_mode_sequencer #(
    parameter logic [15:0] FAULT_SETTLE_DELAY_US_DEFAULT = hms_pkg::FDLY_RST_US,
    parameter logic [11:0] DAC_MIN_CODE         = hms_pkg::DAC_MIN_RST
) (
    input  wire logic        core_clk_i,
    input  wire logic        resetn_i,
    // APB slave.
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Pins and analog indications, all asynchronous.
    input  wire logic        enable_low_input_i,
    input  wire logic        supply_ok_i,
    input  wire logic        bias_ready_i,
    input  wire logic        pump_ready_i,
    input  wire logic        output_ready_i,
    input  wire logic        fault_i,
    // Playback engine, same clock.
    input  wire logic        haptic_done_i,
    // Power and converter controls.
    output logic             osc_bias_en_o,
    output logic             charge_pump_en_o,
    output logic             analog_en_o,
    output logic             converter_en_o,
    output logic      [11:0] dac_code_o,
    output logic             playback_o,
    output logic             clear_mem_o,
    output logic             stream_wr_o,
    output logic      [11:0] stream_data_o
);

    hms_pkg::hms_state_t state;
    hms_pkg::hms_state_t next_state;

    logic        en_low_s;
    logic        supply_s;
    logic        bias_s;
    logic        pump_s;
    logic        out_rdy_s;
    logic        fault_s;
    logic [1:0]  flags;
    logic [1:0]  taken;
    logic        play_en;
    logic        rearm;
    logic [15:0] fdly;
    logic        stream_req;
    logic [31:0] rd_cap;
    logic [2:0]  step_cnt;
    logic [4:0]  us_cnt;
    logic [15:0] dly_cnt;
    logic [11:0] dac_code;

    //--------------------------------------------------------------------
    // Synchronisers.
    //--------------------------------------------------------------------
    // All six asynchronous inputs share one two-flop stage.
    hms_sync #(
        .W (6)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .async_i    ({enable_low_input_i, supply_ok_i, bias_ready_i,
                      pump_ready_i, output_ready_i, fault_i}),
        .sync_o     ({en_low_s, supply_s, bias_s,
                      pump_s, out_rdy_s, fault_s})
    );

    //--------------------------------------------------------------------
    // APB decode.
    //--------------------------------------------------------------------
    // In shutdown no access has any effect and every one errors out.
    wire live    = (state != hms_pkg::ST_SHUTDOWN);
    wire setup   = psel_i & ~penable_i;
    wire access  = psel_i & penable_i;
    wire a_intr  = (paddr_i == hms_pkg::INTR_STAT_ADDR);
    wire a_ctrl  = (paddr_i == hms_pkg::CTRL_ADDR);
    wire a_fdly  = (paddr_i == hms_pkg::FDLY_ADDR);
    wire a_queue = (paddr_i == hms_pkg::QUEUE_ADDR);
    wire a_mode  = (paddr_i == hms_pkg::MODE_ADDR);
    wire mapped  = a_intr | a_ctrl | a_fdly | a_queue | a_mode;
    wire wr_ok   = access & pwrite_i & mapped & live;
    wire rd_ok   = access & ~pwrite_i & mapped & live;
    wire wr_ctrl = wr_ok & a_ctrl & pstrb_i[0];
    wire wr_fdlo = wr_ok & a_fdly & pstrb_i[0];
    wire wr_fdhi = wr_ok & a_fdly & pstrb_i[1];
    wire wr_q    = wr_ok & a_queue & (pstrb_i[0] | pstrb_i[1]);
    wire intr_rd = rd_ok & a_intr;

    assign pready_o  = 1'b1;
    assign pslverr_o = access & (~mapped | ~live);

    // Read data is built from flops and captured in the setup cycle.
    wire [31:0] rd_mux =
        a_intr ? {30'h0, flags} :
        a_ctrl ? {30'h0, rearm, play_en} :
        a_fdly ? {16'h0, fdly} :
        a_mode ? {28'h0, state} : 32'h0;

    assign prdata_o = rd_cap;

    //--------------------------------------------------------------------
    // Events and requests.
    //--------------------------------------------------------------------
    wire active    = (state == hms_pkg::ST_PUMP_UP)
                   | (state == hms_pkg::ST_RAMP_UP)
                   | (state == hms_pkg::ST_PLAY)
                   | (state == hms_pkg::ST_RAMP_DOWN)
                   | (state == hms_pkg::ST_OUT_OFF);
    wire fault_hit = fault_s & active;
    wire spr_set   = (state == hms_pkg::ST_WAKE) & bias_s;
    wire done_evt  = (state == hms_pkg::ST_PLAY) & haptic_done_i;
    wire go_off    = en_low_s | ~supply_s;
    wire request   = play_en | stream_req;
    wire ramping   = (state == hms_pkg::ST_RAMP_UP)
                   | (state == hms_pkg::ST_RAMP_DOWN)
                   | (state == hms_pkg::ST_FAULT_RAMP);
    wire tick      = (step_cnt == 3'(hms_pkg::RAMP_STEP_CYCLES - 1));
    wire in_fault  = (state == hms_pkg::ST_FAULT_RAMP)
                   | (state == hms_pkg::ST_FAULT_WAIT);
    wire us_tick   = (us_cnt == 5'(hms_pkg::US_CYCLES - 1));
    wire dly_done  = (dly_cnt >= fdly);

    // A read clears only the bits it returned, so a flag set meanwhile,
    // or in the same cycle, survives.
    wire [1:0] set_bits  = {fault_hit, spr_set};
    wire [1:0] clr_bits  = intr_rd ? taken : 2'h0;
    wire [1:0] next_flag = (flags & ~clr_bits) | set_bits;

    //--------------------------------------------------------------------
    // Next-state logic.
    //--------------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            hms_pkg::ST_SHUTDOWN: begin
                if (supply_s && !en_low_s) begin
                    next_state = hms_pkg::ST_WAKE;
                end
            end
            hms_pkg::ST_WAKE: begin
                if (go_off) begin
                    next_state = hms_pkg::ST_SHUTDOWN;
                end else if (bias_s) begin
                    next_state = hms_pkg::ST_STBY_PEND;
                end
            end
            hms_pkg::ST_STBY_PEND: begin
                // Requests are refused here until the status is read.
                if (go_off) begin
                    next_state = hms_pkg::ST_SHUTDOWN;
                end else if (intr_rd) begin
                    next_state = hms_pkg::ST_STBY;
                end
            end
            hms_pkg::ST_STBY: begin
                if (go_off) begin
                    next_state = hms_pkg::ST_SHUTDOWN;
                end else if (request) begin
                    next_state = hms_pkg::ST_PUMP_UP;
                end
            end
            hms_pkg::ST_PUMP_UP: begin
                if (fault_hit) begin
                    next_state = hms_pkg::ST_FAULT_RAMP;
                end else if (pump_s) begin
                    next_state = hms_pkg::ST_RAMP_UP;
                end
            end
            hms_pkg::ST_RAMP_UP: begin
                if (fault_hit) begin
                    next_state = hms_pkg::ST_FAULT_RAMP;
                end else if (dac_code == DAC_MIN_CODE && out_rdy_s) begin
                    next_state = hms_pkg::ST_PLAY;
                end
            end
            hms_pkg::ST_PLAY: begin
                if (fault_hit) begin
                    next_state = hms_pkg::ST_FAULT_RAMP;
                end else if (haptic_done_i) begin
                    next_state = hms_pkg::ST_RAMP_DOWN;
                end
            end
            hms_pkg::ST_RAMP_DOWN: begin
                if (fault_hit) begin
                    next_state = hms_pkg::ST_FAULT_RAMP;
                end else if (dac_code == 12'h000) begin
                    next_state = hms_pkg::ST_OUT_OFF;
                end
            end
            hms_pkg::ST_OUT_OFF: begin
                if (fault_hit) begin
                    next_state = hms_pkg::ST_FAULT_RAMP;
                end else if (go_off) begin
                    next_state = hms_pkg::ST_SHUTDOWN;
                end else begin
                    next_state = hms_pkg::ST_STBY;
                end
            end
            hms_pkg::ST_FAULT_RAMP: begin
                if (dac_code <= DAC_MIN_CODE) begin
                    next_state = hms_pkg::ST_FAULT_WAIT;
                end
            end
            hms_pkg::ST_FAULT_WAIT: begin
                if (!dly_done) begin
                    next_state = hms_pkg::ST_FAULT_WAIT;
                end else if (go_off) begin
                    next_state = hms_pkg::ST_SHUTDOWN;
                end else if (rearm) begin
                    next_state = hms_pkg::ST_STBY;
                end else begin
                    next_state = hms_pkg::ST_STBY_PEND;
                end
            end
            default: begin
                next_state = hms_pkg::ST_SHUTDOWN;
            end
        endcase
    end

    //--------------------------------------------------------------------
    // Power controls decoded from the mode.
    //--------------------------------------------------------------------
    // The converter drops before the pumps on both ramp-down paths.
    assign osc_bias_en_o    = live;
    assign charge_pump_en_o = active | in_fault;
    assign analog_en_o      = active | in_fault;
    assign converter_en_o   = ramping | (state == hms_pkg::ST_PLAY);
    assign playback_o       = (state == hms_pkg::ST_PLAY);
    assign dac_code_o       = dac_code;

    //--------------------------------------------------------------------
    // Mode register and shutdown clear pulse.
    //--------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state       <= hms_pkg::ST_SHUTDOWN;
            clear_mem_o <= 1'b0;
        end else begin
            state       <= next_state;
            clear_mem_o <= live && (next_state == hms_pkg::ST_SHUTDOWN);
        end
    end

    //--------------------------------------------------------------------
    // Software registers; all are wiped while in shutdown.
    //--------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flags <= hms_pkg::FLAGS_RST;
            taken <= hms_pkg::FLAGS_RST;
            rd_cap <= 32'h0;
        end else if (!live) begin
            flags <= hms_pkg::FLAGS_RST;
            taken <= hms_pkg::FLAGS_RST;
            rd_cap <= 32'h0;
        end else begin
            flags <= next_flag;
            if (setup) begin
                taken  <= a_intr ? flags : 2'h0;
                rd_cap <= rd_mux;
            end
        end
    end

    // Play enable drops on its own when the event completes.
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            play_en <= 1'b0;
            rearm   <= 1'b0;
            fdly    <= FAULT_SETTLE_DELAY_US_DEFAULT;
        end else if (!live) begin
            play_en <= 1'b0;
            rearm   <= 1'b0;
            fdly    <= FAULT_SETTLE_DELAY_US_DEFAULT;
        end else begin
            if (wr_ctrl) begin
                play_en <= pwdata_i[hms_pkg::PLAY_EN_POS];
                rearm   <= pwdata_i[hms_pkg::REARM_POS];
            end else if (done_evt) begin
                play_en <= 1'b0;
            end
            if (wr_fdlo) begin
                fdly[7:0] <= pwdata_i[7:0];
            end
            if (wr_fdhi) begin
                fdly[15:8] <= pwdata_i[15:8];
            end
        end
    end

    // Queue writes reach the queue in every mode but shutdown; only in standby do they start
    // an event, so a write during pending standby is not remembered.
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stream_req    <= 1'b0;
            stream_wr_o   <= 1'b0;
            stream_data_o <= 12'h000;
        end else begin
            stream_wr_o <= wr_q;
            if (wr_q) begin
                stream_data_o <= pwdata_i[11:0];
            end
            if (!live || state != hms_pkg::ST_STBY) begin
                stream_req <= 1'b0;
            end else if (wr_q) begin
                stream_req <= 1'b1;
            end
        end
    end

    //--------------------------------------------------------------------
    // Converter code ramp, one step per RAMP_STEP_CYCLES.
    //--------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            step_cnt <= 3'h0;
            dac_code <= 12'h000;
        end else begin
            step_cnt <= (ramping && !tick) ? step_cnt + 3'h1 : 3'h0;
            if (next_state < hms_pkg::ST_PUMP_UP) begin // No stale code.
                dac_code <= 12'h000;
            end else if (tick) begin
                if (state == hms_pkg::ST_RAMP_UP &&
                    dac_code < DAC_MIN_CODE) begin
                    dac_code <= dac_code + 12'h001;
                end else if (state == hms_pkg::ST_RAMP_DOWN &&
                             dac_code != 12'h000) begin
                    dac_code <= dac_code - 12'h001;
                end else if (state == hms_pkg::ST_FAULT_RAMP &&
                             dac_code > DAC_MIN_CODE) begin
                    dac_code <= dac_code - 12'h001;
                end
            end
        end
    end

    //--------------------------------------------------------------------
    // Fault settle delay, counted in microseconds from the fault.
    //--------------------------------------------------------------------
    // Counting from the fault, not from the ramp end, bounds the time the
    // pumps stay up; a ramp longer than the delay cuts ST_FAULT_WAIT to one cycle.
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            us_cnt  <= 5'h00;
            dly_cnt <= 16'h0000;
        end else if (!in_fault) begin
            us_cnt  <= 5'h00;
            dly_cnt <= 16'h0000;
        end else if (us_tick) begin
            us_cnt <= 5'h00;
            if (!dly_done) begin
                dly_cnt <= dly_cnt + 16'h0001;
            end
        end else begin
            us_cnt <= us_cnt + 5'h01;
        end
    end

endmodule // hms_haptic_mode_sequencer
`default_nettype wire

// ==== hms_checker_assertions.sv ====
// Port checker of the haptic mode sequencer.
`timescale 1ns/1ns
`default_nettype none
module hms_checker #(
    parameter logic [11:0] DAC_MIN_CODE = 12'h100
) (
    input wire logic        core_clk_i,
    input wire logic        resetn_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        enable_low_input_i,
    input wire logic        supply_ok_i,
    input wire logic        output_ready_i,
    input wire logic        osc_bias_en_o,
    input wire logic        charge_pump_en_o,
    input wire logic        converter_en_o,
    input wire logic [11:0] dac_code_o,
    input wire logic        playback_o,
    input wire logic        clear_mem_o,
    input wire logic        pslverr_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // Power-up order and ramp shape; one clock domain only.
    property p_off;
        !osc_bias_en_o |-> !charge_pump_en_o && !converter_en_o
            && (!(psel_i && penable_i) || pslverr_o);
    endproperty
    property p_idle;
        !charge_pump_en_o |-> !converter_en_o && !playback_o
            && dac_code_o == 12'h000;
    endproperty
    property p_pump_first;
        $rose(converter_en_o) |-> $past(charge_pump_en_o);
    endproperty
    property p_play;
        $rose(playback_o) |-> dac_code_o == DAC_MIN_CODE
            && $past(output_ready_i, 2);
    endproperty
    // A jump in the code would kick the output; steps are one LSB.
    property p_step;
        charge_pump_en_o && $past(charge_pump_en_o) |->
            (dac_code_o - $past(dac_code_o)) inside {12'h000, 12'h001, 12'hfff};
    endproperty
    property p_pumps_last;
        $fell(charge_pump_en_o) |-> !$past(converter_en_o);
    endproperty
    property p_shut;
        $rose(enable_low_input_i) && !charge_pump_en_o |-> ##[1:6] !osc_bias_en_o;
    endproperty
    property p_clr;
        $fell(osc_bias_en_o) |-> ##[0:2] clear_mem_o;
    endproperty
    property p_sync;
        $fell(enable_low_input_i) && supply_ok_i && !osc_bias_en_o |->
            !osc_bias_en_o ##1 !osc_bias_en_o ##[1:3] osc_bias_en_o;
    endproperty
    a_off: assert property (p_off) else $error("live in shutdown");
    a_idle: assert property (p_idle) else $error("output live");
    a_pump_first: assert property (p_pump_first)
        else $error("order");
    a_play: assert property (p_play) else $error("early play");
    a_step: assert property (p_step) else $error("code jump");
    a_pumps_last: assert property (p_pumps_last)
        else $error("pumps");
    a_shut: assert property (p_shut) else $error("no shutdown");
    a_clr: assert property (p_clr) else $error("no clear");
    a_sync: assert property (p_sync) else $error("wake timing");
    c_play: cover property ($rose(playback_o));
    c_wait: cover property ($fell(converter_en_o) && charge_pump_en_o);
    c_wake: cover property ($rose(osc_bias_en_o));
endmodule // hms_checker
bind hms_haptic_mode_sequencer hms_checker #(.DAC_MIN_CODE(DAC_MIN_CODE)) u_chk (
    .core_clk_i, .resetn_i, .psel_i, .penable_i, .enable_low_input_i,
    .supply_ok_i, .output_ready_i, .osc_bias_en_o, .charge_pump_en_o,
    .converter_en_o, .dac_code_o, .playback_o, .clear_mem_o, .pslverr_o);
`default_nettype wire

// ==== hms_analog_model.sv ====
// Behavioural model of the bias, charge pumps and output stage.
`timescale 1ns/1ns
`default_nettype none
module hms_analog_model #(
    parameter logic [11:0] DAC_MIN_CODE = 12'h100
) (
    input  wire logic        core_clk_i,
    input  wire logic        slow_i,
    input  wire logic        osc_bias_en_i,
    input  wire logic        charge_pump_en_i,
    input  wire logic        converter_en_i,
    input  wire logic [11:0] dac_code_i,
    output logic             bias_ready_o,
    output logic             pump_ready_o,
    output logic             output_ready_o
);
    logic [5:0] pump_cnt;
    // Slow mode stretches pump start so the sequencer must really wait.
    always_ff @(posedge core_clk_i) begin
        bias_ready_o   <= osc_bias_en_i;
        pump_cnt       <= charge_pump_en_i ?
                          pump_cnt + {5'h00, pump_cnt != 6'h3f} : 6'h00;
        pump_ready_o   <= pump_cnt >= (slow_i ? 6'h30 : 6'h03);
        output_ready_o <= converter_en_i && dac_code_i >= DAC_MIN_CODE;
    end
endmodule // hms_analog_model
`default_nettype wire

// ==== haptic_mode_sequencer_tb.sv ====
// Self-checking testbench of the haptic mode sequencer.
`timescale 1ns/1ns
`default_nettype none
module haptic_mode_sequencer_tb;
    localparam logic [11:0] MIN = 12'h004;
    logic core_clk_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0;
    logic pwrite_i = 0, fault_i = 0, haptic_done_i = 0, slow = 0;
    logic enable_low_input_i = 1, supply_ok_i = 1, er;
    logic [7:0] paddr_i = 0;
    logic [31:0] pwdata_i = 0, prdata_o, rd;
    logic pready_o, pslverr_o, bias_ready_i, pump_ready_i, output_ready_i;
    logic osc_bias_en_o, charge_pump_en_o, analog_en_o, converter_en_o;
    logic playback_o;
    logic [11:0] dac_code_o, sdata;
    int n_errors = 0, compares = 0, n;
    hms_haptic_mode_sequencer #(.DAC_MIN_CODE(MIN)) u_dut (.core_clk_i,
        .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .pstrb_i(4'hf), .prdata_o, .pready_o, .pslverr_o, .enable_low_input_i,
        .supply_ok_i, .bias_ready_i, .pump_ready_i, .output_ready_i, .fault_i,
        .haptic_done_i, .osc_bias_en_o, .charge_pump_en_o, .analog_en_o,
        .converter_en_o, .dac_code_o, .playback_o, .clear_mem_o(),
        .stream_wr_o(), .stream_data_o(sdata));
    hms_analog_model #(.DAC_MIN_CODE(MIN)) u_ana (.core_clk_i, .slow_i(slow),
        .osc_bias_en_i(osc_bias_en_o), .charge_pump_en_i(charge_pump_en_o),
        .converter_en_i(converter_en_o), .dac_code_i(dac_code_o),
        .bias_ready_o(bias_ready_i), .pump_ready_o(pump_ready_i),
        .output_ready_o(output_ready_i));
    always #25 core_clk_i = ~core_clk_i;
    task chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // The answer is taken at the edge that samples pready high, no sooner.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do @(posedge core_clk_i); while (pready_o !== 1'b1);
        {rd, er} = {prdata_o, pslverr_o};
        {psel_i, penable_i} <= 2'b00;
    endtask
    task poll(input logic [31:0] m);
        for (int j = 0; j < 100; j++) begin
            apb(0, hms_pkg::MODE_ADDR, 0);
            if (er === 1'b0 && rd === m) break;
        end
        chk(rd, m);
    endtask
    task wake;
        enable_low_input_i <= 1'b0;
        poll(2);
    endtask
    task done;
        @(posedge core_clk_i) haptic_done_i <= 1'b1;
        @(posedge core_clk_i) haptic_done_i <= 1'b0;
    endtask
    task start(input logic k);
        if (k) apb(1, hms_pkg::CTRL_ADDR, 32'h1);
        else apb(1, hms_pkg::QUEUE_ADDR, 32'h0ab);
        for (n = 0; n < 500 && playback_o !== 1'b1; n++) @(posedge core_clk_i);
        chk({playback_o, analog_en_o}, 2'b11);
        chk({dac_code_o, sdata}, {MIN, 12'h0ab});
    endtask
    task t_off;
        apb(0, hms_pkg::MODE_ADDR, 0);
        chk(er, 1);
        chk(osc_bias_en_o, 0);
        $display("t_off finished");
    endtask
    task t_wake;
        wake();
        apb(1, hms_pkg::QUEUE_ADDR, 32'h123);
        repeat (20) @(posedge core_clk_i);
        apb(0, hms_pkg::MODE_ADDR, 0);
        chk(rd, 2);
        apb(0, hms_pkg::INTR_STAT_ADDR, 0);
        chk(rd[1:0], 1);
        apb(0, hms_pkg::MODE_ADDR, 0);
        chk(rd, 3);
        $display("t_wake finished");
    endtask
    task t_play;
        for (int k = 0; k < 2; k++) begin
            slow = k[0];
            start(k[0]);
            done();
            for (n = 0; n < 300 && charge_pump_en_o !== 1'b0; n++)
                @(posedge core_clk_i);
            chk(dac_code_o, 0);
            apb(0, hms_pkg::MODE_ADDR, 0);
            chk(rd, 3);
        end
        $display("t_play finished");
    endtask
    task t_fault;
        for (int r = 0; r < 2; r++) begin
            apb(1, hms_pkg::FDLY_ADDR, 32'h2);
            apb(1, hms_pkg::CTRL_ADDR, {30'h0, r[0], 1'b0});
            start(0);
            fault_i <= 1'b1;
            for (n = 0; n < 500 && converter_en_o === 1'b1; n++)
                @(posedge core_clk_i);
            chk(dac_code_o, MIN);
            for (; n < 500 && charge_pump_en_o === 1'b1; n++)
                @(posedge core_clk_i);
            fault_i <= 1'b0;
            chk(n >= 40 && n < 60, 1);
            apb(0, hms_pkg::MODE_ADDR, 0);
            chk(rd, r ? 3 : 2);
            apb(0, hms_pkg::INTR_STAT_ADDR, 0);
            if (r == 0) chk(rd[1], 1);
        end
        $display("t_fault finished");
    endtask
    task t_shut;
        enable_low_input_i <= 1'b1;
        for (n = 0; n < 50 && osc_bias_en_o !== 1'b0; n++) @(posedge core_clk_i);
        chk(osc_bias_en_o, 0);
        wake();
        apb(0, hms_pkg::INTR_STAT_ADDR, 0);
        start(0);
        enable_low_input_i <= 1'b1;
        done();
        for (n = 0; n < 300 && osc_bias_en_o !== 1'b0; n++) @(posedge core_clk_i);
        chk(osc_bias_en_o, 0);
        wake();
        apb(0, hms_pkg::FDLY_ADDR, 0);
        chk(rd[15:0], hms_pkg::FDLY_RST_US);
        $display("t_shut finished");
    endtask
    task wrap_up;
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        t_off();
        t_wake();
        t_play();
        t_fault();
        t_shut();
        wrap_up();
    end
    // The whole run needs a few hundred cycles; this cuts a hang short.
    initial begin
        #1000000;
        n_errors++;
        wrap_up();
    end
endmodule // haptic_mode_sequencer_tb
`default_nettype wire
